// ### pkg/bbalu_map.vh
// Register offsets, field positions, opcodes and reset values of the ALU block.
`ifndef BBALU_MAP_VH
`define BBALU_MAP_VH
`define BBALU_REG_CTRL 8'h00
`define BBALU_REG_INSTR 8'h04
`define BBALU_REG_ACC 8'h08
`define BBALU_REG_STATUS 8'h0C
`define BBALU_REG_FILE 8'h10
`define BBALU_REG_PINS 8'h14
`define BBALU_REG_PORTMAP 8'h18
`define BBALU_CTRL_EXEC 0
`define BBALU_ST_CARRY 0
`define BBALU_ST_NIB 1
`define BBALU_ST_NULL 2
`define BBALU_ST_ILLEGAL 3
`define BBALU_TGT_BIT 5
`define BBALU_IDX_HI 4
`define BBALU_POS_HI 7
`define BBALU_POS_LO 5
`define BBALU_OP_SUM 6'h07
`define BBALU_OP_MASKR 6'h05
`define BBALU_OP_MASKI 4'hE
`define BBALU_OP_LOWER 4'h4
`define BBALU_ACC_RST 8'h00
`define BBALU_PORTMAP_RST 32'h00000060
`endif

// ### logic/bbalu_exec.v
// Combinational execute unit: decodes one instruction word and forms its result.
`timescale 1ns/10ps
`default_nettype none
`include "bbalu_map.vh"
module bbalu_exec (
	// Instruction and operands.
	input wire [11:0] instr,
	input wire [7:0] acc,
	input wire [7:0] operand,
	// Results.
	output reg [7:0] result,
	output reg to_file,
	output reg to_acc,
	output reg upd_carry,
	output reg upd_null,
	output reg carry,
	output reg nib,
	output reg illegal
);
	wire [8:0] sum;
	wire [4:0] low_sum;
	wire [2:0] pos;
	assign sum = {1'b0, acc} + {1'b0, operand};
	assign low_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
	assign pos = instr[`BBALU_POS_HI:`BBALU_POS_LO];
	always @* begin
		result = 8'h00;
		to_file = 1'b0;
		to_acc = 1'b0;
		upd_carry = 1'b0;
		upd_null = 1'b0;
		carry = sum[8];
		nib = low_sum[4];
		illegal = 1'b0;
		if (instr[11:6] == `BBALU_OP_SUM) begin
			result = sum[7:0];
			upd_carry = 1'b1;
			upd_null = 1'b1;
			to_file = instr[`BBALU_TGT_BIT];
			to_acc = ~instr[`BBALU_TGT_BIT];
		end else if (instr[11:6] == `BBALU_OP_MASKR) begin
			result = acc & operand;
			upd_null = 1'b1;
			to_file = instr[`BBALU_TGT_BIT];
			to_acc = ~instr[`BBALU_TGT_BIT];
		end else if (instr[11:8] == `BBALU_OP_MASKI) begin
			result = acc & instr[7:0];
			upd_null = 1'b1;
			to_acc = 1'b1;
		end else if (instr[11:8] == `BBALU_OP_LOWER) begin
			result = operand & ~(8'h01 << pos);
			to_file = 1'b1;
		end else begin
			illegal = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### logic/bbalu_top.v
// AXI4-Lite wrapped execute stage for four byte and bit ALU instructions.
// Contract
// - Sum opcode adds accumulator and file register; sets carry, nibble carry, zero.
// - Target bit 0 writes accumulator; 1 writes back to the file register.
// - Mask immediate ANDs accumulator with literal; result to accumulator; zero only.
// - Mask register ANDs accumulator with file register; routed by target; zero only.
// - Byte operations: target bit at 5, register index in bits 4 to 0.
// - Bit operations: position in bits 7 to 5, register index in 4 to 0.
// - Literal operations take the immediate from the low eight bits.
// - Port register as operand and destination reads pin levels, not latch.
`timescale 1ns/10ps
`default_nettype none
`include "bbalu_map.vh"
module bbalu_top #(
	parameter NREGS = 32
) (
	// Clock and reset.
	input wire aclk,
	input wire aresetn,
	// Write address channel.
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// Write data channel.
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// Write response channel.
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// Read address channel.
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// Read data channel.
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Port pins.
	input wire [7:0] pin_levels,
	output reg [7:0] port_latch_q
);
	reg [7:0] files_q [0:NREGS-1];
	reg [7:0] acc_q;
	reg [3:0] status_q;
	reg [11:0] instr_q;
	reg [31:0] portmap_q;
	reg [7:0] pin_meta_q;
	reg [7:0] pin_sync_q;
	reg [7:0] awaddr_q;
	reg aw_have_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg w_have_q;
	reg [7:0] file_idx_q;
	reg exec_q;
	wire [4:0] idx;
	wire is_port;
	wire [7:0] operand;
	wire [7:0] result;
	wire to_file;
	wire to_acc;
	wire upd_carry;
	wire upd_null;
	wire carry;
	wire nib;
	wire illegal;
	wire do_write;
	wire [31:0] instr_merged;
	integer i;
	// Merges byte lanes of a write into an old word.
	function [31:0] bbalu_merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer k;
		begin
			bbalu_merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k]) begin
					bbalu_merge[8*k +: 8] = data[8*k +: 8];
				end
			end
		end
	endfunction
	// True when the index names a register whose bit is set in the port map.
	function bbalu_port_hit;
		input [4:0] ix;
		input [31:0] map;
		begin
			bbalu_port_hit = map[ix];
		end
	endfunction
	assign idx = instr_q[`BBALU_IDX_HI:0];
	assign is_port = bbalu_port_hit(idx, portmap_q);
	assign operand = is_port ? pin_sync_q : files_q[idx];
	assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
	assign instr_merged = bbalu_merge({20'h00000, instr_q}, wdata_q, wstrb_q);
	bbalu_exec u_exec (
		.instr(instr_q),
		.acc(acc_q),
		.operand(operand),
		.result(result),
		.to_file(to_file),
		.to_acc(to_acc),
		.upd_carry(upd_carry),
		.upd_null(upd_null),
		.carry(carry),
		.nib(nib),
		.illegal(illegal)
	);
	// Pin synchroniser.
	always @(posedge aclk) begin
		pin_meta_q <= pin_levels;
		pin_sync_q <= pin_meta_q;
	end
	// Write channels, register writes and instruction execution.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			acc_q <= `BBALU_ACC_RST;
			status_q <= 4'h0;
			instr_q <= 12'h000;
			portmap_q <= `BBALU_PORTMAP_RST;
			file_idx_q <= 8'h00;
			exec_q <= 1'b0;
			port_latch_q <= 8'h00;
			for (i = 0; i < NREGS; i = i + 1) begin
				files_q[i] <= 8'h00;
			end
		end else begin
			exec_q <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
				aw_have_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_have_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				case (awaddr_q)
				`BBALU_REG_CTRL: begin
					if (wstrb_q[0] && wdata_q[`BBALU_CTRL_EXEC]) begin
						exec_q <= 1'b1;
					end
				end
				`BBALU_REG_INSTR: instr_q <= instr_merged[11:0];
				`BBALU_REG_ACC: if (wstrb_q[0]) acc_q <= wdata_q[7:0];
				`BBALU_REG_STATUS: if (wstrb_q[0]) status_q <= wdata_q[3:0];
				`BBALU_REG_FILE: if (wstrb_q[0]) file_idx_q <= wdata_q[7:0];
				`BBALU_REG_PINS: begin
					if (wstrb_q[1]) begin
						files_q[file_idx_q[4:0]] <= wdata_q[15:8];
						if (bbalu_port_hit(file_idx_q[4:0], portmap_q)) begin
							port_latch_q <= wdata_q[15:8];
						end
					end
				end
				`BBALU_REG_PORTMAP: portmap_q <= bbalu_merge(portmap_q, wdata_q, wstrb_q);
				default: s_axi_bresp <= 2'b10;
				endcase
			end
			if (exec_q) begin
				if (to_acc) begin
					acc_q <= result;
				end
				if (to_file) begin
					files_q[idx] <= result;
					if (is_port) begin
						port_latch_q <= result;
					end
				end
				if (upd_carry) begin
					status_q[`BBALU_ST_CARRY] <= carry;
					status_q[`BBALU_ST_NIB] <= nib;
				end
				if (upd_null) begin
					status_q[`BBALU_ST_NULL] <= (result == 8'h00);
				end
				status_q[`BBALU_ST_ILLEGAL] <= illegal;
			end
		end
	end
	// Read channels.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr)
				`BBALU_REG_CTRL: s_axi_rdata <= 32'h00000000;
				`BBALU_REG_INSTR: s_axi_rdata <= {20'h00000, instr_q};
				`BBALU_REG_ACC: s_axi_rdata <= {24'h000000, acc_q};
				`BBALU_REG_STATUS: s_axi_rdata <= {28'h0000000, status_q};
				`BBALU_REG_FILE: s_axi_rdata <= {24'h000000, file_idx_q};
				`BBALU_REG_PINS: s_axi_rdata <= {16'h0000, files_q[file_idx_q[4:0]], pin_sync_q};
				`BBALU_REG_PORTMAP: s_axi_rdata <= portmap_q;
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/bbalu_props.sv
// Bus handshake checker for the byte and bit ALU block.
`timescale 1ns/10ps
`default_nettype none
module bbalu_props (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Write channels.
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels.
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	b_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write response late");
	aw_blk_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write response not closed");
	r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	ar_blk_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
	r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data not closed");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
	cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);
	cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h2);
endmodule
bind bbalu_top bbalu_props i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ### tb/tb_byte_and_bit_alu_ops.sv
// Testbench for the byte and bit ALU block.
`timescale 1ns/10ps
`default_nettype none
`include "bbalu_map.vh"
module tb_byte_and_bit_alu_ops;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, pin_levels, port_latch_q;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [1:0] wr_resp = 2'h3;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	int err_count = 0, n_compared = 0;
	bbalu_top i_dut (.*);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic cmp(input [47:0] nm, input [31:0] e, input [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %0s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input [7:0] a, input [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		wr_resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic run(input [11:0] i);
		wr(`BBALU_REG_INSTR, {20'h0, i});
		wr(`BBALU_REG_CTRL, 32'h1);
		repeat (3) @(posedge aclk);
	endtask
	task automatic setf(input [7:0] i, input [7:0] v);
		wr(`BBALU_REG_FILE, {24'h0, i});
		wr(`BBALU_REG_PINS, {16'h0, v, 8'h0});
	endtask
	task automatic chk(input [7:0] a, input [7:0] f, input [3:0] s);
		logic [31:0] d;
		logic [1:0] r;
		rd(`BBALU_REG_ACC, d, r);
		cmp("acc", {24'h0, a}, d);
		rd(`BBALU_REG_PINS, d, r);
		cmp("file", {24'h0, f}, {24'h0, d[15:8]});
		rd(`BBALU_REG_STATUS, d, r);
		cmp("status", {28'h0, s}, d);
	endtask
	task automatic t_sum;
		setf(8'h03, 8'hC2);
		wr(`BBALU_REG_ACC, 32'h17);
		run(12'h1C3);
		chk(8'hD9, 8'hC2, 4'h0);
		wr(`BBALU_REG_ACC, 32'h88);
		setf(8'h03, 8'h78);
		run(12'h1E3);
		chk(8'h88, 8'h00, 4'h7);
	endtask
	task automatic t_mask;
		wr(`BBALU_REG_ACC, 32'hA3);
		run(12'hE5F);
		chk(8'h03, 8'h00, 4'h3);
		wr(`BBALU_REG_ACC, 32'h17);
		setf(8'h03, 8'hC2);
		run(12'h163);
		chk(8'h17, 8'h02, 4'h3);
		wr(`BBALU_REG_ACC, 32'h0F);
		setf(8'h03, 8'hF0);
		run(12'h143);
		chk(8'h00, 8'hF0, 4'h7);
	endtask
	task automatic t_lower;
		setf(8'h03, 8'hC7);
		run(12'h4E3);
		chk(8'h00, 8'h47, 4'h7);
		wr(`BBALU_REG_FILE, 32'h5);
		run(12'h445);
		cmp("latch", 32'h38, {24'h0, port_latch_q});
	endtask
	task automatic t_unmapped;
		logic [31:0] d;
		logic [1:0] r;
		rd(8'h1C, d, r);
		cmp("resp", 32'h2, {30'h0, r});
		cmp("rdata", 32'h0, d);
		wr(8'h1C, 32'h0);
		cmp("bresp", 32'h2, {30'h0, wr_resp});
		run(12'hC00);
		cmp("bresp", 32'h0, {30'h0, wr_resp});
		chk(8'h00, 8'h38, 4'hF);
	endtask
	task automatic t_reset;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		cmp("latch", 32'h0, {24'h0, port_latch_q});
		chk(8'h00, 8'h00, 4'h0);
	endtask
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		close_out();
	end
	initial begin
		aresetn = 1'b0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		pin_levels = 8'h3C;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_sum();
		t_mask();
		t_lower();
		t_unmapped();
		t_reset();
		close_out();
	end
endmodule
`default_nettype wire
